// file: psm_cfg.svh
// timing counts and widths for the power state manager
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH

`define PSM_CLK_PERIOD_NS 4
`define PSM_OSC_SETTLE_NS 1000
`define PSM_SETTLE_CYCLES ((`PSM_OSC_SETTLE_NS + `PSM_CLK_PERIOD_NS - 1) / `PSM_CLK_PERIOD_NS)
`define PSM_SETTLE_W 9
`define PSM_SYNC_W 6
`define PSM_PERIPH_N 4
`define PSM_RESET_RETURN_SLOW 1'b0
`define PSM_RESET_CTRL 8'h2f

`endif

// file: psm_pkg.sv
// types shared by the power state manager files
package psm_pkg;

  typedef enum logic [4:0] {
    PS_RUN = 5'h01,
    PS_SLOW = 5'h02,
    PS_IDLE = 5'h04,
    PS_SLEEP = 5'h08,
    PS_DEEP = 5'h10
  } psm_pstate_t;

  typedef enum logic [8:0] {
    ST_RUN = 9'h001,
    ST_SLOW = 9'h002,
    ST_IDLEREQ = 9'h004,
    ST_IDLE = 9'h008,
    ST_SRENTER = 9'h010,
    ST_SLEEP = 9'h020,
    ST_DEEP = 9'h040,
    ST_WAKEOSC = 9'h080,
    ST_WAKESR = 9'h100
  } psm_state_t;

  typedef struct packed {
    logic cpuHalfRate;
    logic busRequest;
    logic sdramRefresh;
    logic selfRefreshReq;
    logic internalClockOn;
    logic mainOscOn;
    logic pllOn;
    logic peripheralPowerOn;
  } psm_ctrl_t;

  typedef struct packed {
    logic user;
    logic rtcAlarm;
    logic resetReq;
    logic modemRing;
  } psm_wake_t;

endpackage : psm_pkg

// file: psm_sync.sv
// two-flop synchroniser for the asynchronous pins of the power state manager
`timescale 1ns/10ps
`include "psm_cfg.svh"

module psm_sync (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [`PSM_SYNC_W-1:0] din,
  output logic [`PSM_SYNC_W-1:0] dout
);

  logic [`PSM_SYNC_W-1:0] stage1;

  // stage1 is read only by dout
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule : psm_sync

// file: psm_power_state_manager.sv
// power state manager: system power state machine with wake and clock control
`timescale 1ns/10ps
`include "psm_cfg.svh"

// Notes on behaviour
// [R01] exactly one of five power states
// [R02] run: clocks on, sdram normal refresh
// [R03] slow: cpu runs at half rate
// [R04] idle: request and hold system bus
// [R05] irq or dma request ends idle
// [R06] sleep: self-refresh, internal clocks off
// [R07] sleep only entered from idle with bus
// [R08] deep sleep: main oscillator, plls off
// [R09] only slow oscillator, rtc, wakeup run
// [R10] deep sleep: rest powered down, self-refresh
// [R11] four wake sources end sleep states
// [R12] ring raises interrupt outside sleep states
// [R13] gate idle peripheral clocks, video power
// [R14] wake: clocks, settle, leave self-refresh, release
module psm_power_state_manager
  import psm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic targetValid,
  input wire psm_pstate_t targetState,
  input wire logic busGrant,
  input wire logic cpuIrq,
  input wire logic dmaBusReq,
  input wire logic selfRefreshAck,
  input wire psm_wake_t wakePins,
  input wire logic pllLockPin,
  input wire logic monitorPin,
  input wire logic [`PSM_PERIPH_N-1:0] periphActive,
  output psm_pstate_t powerState,
  output psm_ctrl_t ctrl,
  output logic rtcClockOn,
  output logic modemRingIrq,
  output logic [`PSM_PERIPH_N-1:0] periphClockOn,
  output logic videoPowerOn
);

  localparam logic [`PSM_SETTLE_W-1:0] SETTLE_LAST = `PSM_SETTLE_W'(`PSM_SETTLE_CYCLES - 1);

  psm_state_t state;
  psm_state_t next_state;
  psm_ctrl_t next_ctrl;
  psm_pstate_t next_powerState;
  psm_wake_t wakeSync;
  logic pllLocked;
  logic monitorSync;
  logic returnSlow;
  logic deepPending;
  logic [`PSM_SETTLE_W-1:0] settleCount;
  logic settleDone;
  logic wakeAny;
  logic leaveIdle;
  logic reqRun;
  logic reqSlow;
  logic reqIdle;
  logic reqSleep;
  logic reqDeep;

  psm_sync u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .din({wakePins, pllLockPin, monitorPin}),
    .dout({wakeSync, pllLocked, monitorSync})
  );

  // illegal target codes match none of these and are ignored
  assign reqRun = targetValid && (targetState == PS_RUN);
  assign reqSlow = targetValid && (targetState == PS_SLOW);
  assign reqIdle = targetValid && (targetState == PS_IDLE);
  assign reqSleep = targetValid && (targetState == PS_SLEEP);
  assign reqDeep = targetValid && (targetState == PS_DEEP);
  assign wakeAny = |wakeSync; // see [R11]
  assign leaveIdle = cpuIrq || dmaBusReq; // see [R05]
  assign settleDone = (settleCount == SETTLE_LAST);

  function automatic psm_state_t returnTo(input logic slow);
    returnTo = slow ? ST_SLOW : ST_RUN;
  endfunction : returnTo

  function automatic psm_pstate_t reportOf(input psm_state_t s, input logic slow);
    unique case (s)
      ST_RUN: reportOf = PS_RUN;
      ST_SLOW: reportOf = PS_SLOW;
      ST_IDLEREQ: reportOf = slow ? PS_SLOW : PS_RUN;
      ST_IDLE, ST_SRENTER: reportOf = PS_IDLE;
      ST_SLEEP, ST_WAKESR: reportOf = PS_SLEEP;
      ST_DEEP, ST_WAKEOSC: reportOf = PS_DEEP;
      default: reportOf = PS_RUN;
    endcase
  endfunction : reportOf

  function automatic psm_ctrl_t ctrlOf(input psm_state_t s, input logic slow);
    psm_ctrl_t c;
    c = '{default: 1'b0};
    c.mainOscOn = 1'b1;
    c.pllOn = 1'b1;
    c.peripheralPowerOn = 1'b1;
    unique case (s)
      ST_RUN: begin
        c.internalClockOn = 1'b1; // see [R02]
        c.sdramRefresh = 1'b1;
      end
      ST_SLOW: begin
        c.internalClockOn = 1'b1;
        c.sdramRefresh = 1'b1;
        c.cpuHalfRate = 1'b1; // see [R03]
      end
      ST_IDLEREQ, ST_IDLE: begin
        c.internalClockOn = 1'b1;
        c.sdramRefresh = 1'b1;
        c.busRequest = 1'b1; // see [R04]
        c.cpuHalfRate = slow;
      end
      ST_SRENTER: begin
        // sdram controller still needs its clock to enter self-refresh
        c.internalClockOn = 1'b1;
        c.busRequest = 1'b1;
        c.selfRefreshReq = 1'b1;
      end
      ST_SLEEP, ST_WAKEOSC: begin
        c.busRequest = 1'b1;
        c.selfRefreshReq = 1'b1; // see [R06]
      end
      ST_DEEP: begin
        c.busRequest = 1'b1;
        c.selfRefreshReq = 1'b1; // see [R10]
        c.mainOscOn = 1'b0; // see [R08]
        c.pllOn = 1'b0;
        c.peripheralPowerOn = 1'b0; // see [R10]
      end
      ST_WAKESR: begin
        c.internalClockOn = 1'b1; // see [R14]
        c.sdramRefresh = 1'b1;
        c.busRequest = 1'b1;
        c.cpuHalfRate = slow;
      end
      default: c = '{default: 1'b0};
    endcase
    ctrlOf = c;
  endfunction : ctrlOf

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (reqSlow) next_state = ST_SLOW;
        else if (reqIdle) next_state = ST_IDLEREQ;
      end
      ST_SLOW: begin
        if (reqRun) next_state = ST_RUN;
        else if (reqIdle) next_state = ST_IDLEREQ;
      end
      ST_IDLEREQ: begin
        // an irq or dma request seen before the grant abandons the idle request
        if (leaveIdle) next_state = returnTo(returnSlow); // see [R05]
        else if (busGrant) next_state = ST_IDLE; // see [R04]
      end
      ST_IDLE: begin
        if (leaveIdle) next_state = returnTo(returnSlow); // see [R05]
        else if (reqRun) next_state = ST_RUN;
        else if (reqSlow) next_state = ST_SLOW;
        else if (reqSleep || reqDeep) next_state = ST_SRENTER; // see [R07]
      end
      ST_SRENTER: begin
        if (selfRefreshAck) next_state = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wakeAny) next_state = ST_WAKESR; // see [R11]
        else if (deepPending || reqDeep) next_state = ST_DEEP;
      end
      ST_DEEP: begin
        if (wakeAny) next_state = ST_WAKEOSC; // see [R11]
      end
      ST_WAKEOSC: begin
        if (settleDone && pllLocked) next_state = ST_WAKESR; // see [R14]
      end
      ST_WAKESR: begin
        if (!selfRefreshAck) next_state = returnTo(returnSlow); // see [R14]
      end
      default: next_state = ST_RUN;
    endcase
  end

  assign next_ctrl = ctrlOf(next_state, returnSlow);
  assign next_powerState = reportOf(next_state, returnSlow);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state <= ST_RUN;
    else state <= next_state;
  end

  // outputs are registered from the next state so they change with it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= psm_ctrl_t'(`PSM_RESET_CTRL);
      powerState <= PS_RUN;
    end else begin
      ctrl <= next_ctrl;
      powerState <= next_powerState; // see [R01]
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) returnSlow <= `PSM_RESET_RETURN_SLOW;
    else if (next_state == ST_SLOW) returnSlow <= 1'b1;
    else if (next_state == ST_RUN) returnSlow <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) deepPending <= 1'b0;
    else if (state == ST_IDLE && reqDeep && !leaveIdle) deepPending <= 1'b1;
    else if (state == ST_DEEP || state == ST_WAKESR || state == ST_IDLE) deepPending <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) settleCount <= '0;
    else if (state != ST_WAKEOSC) settleCount <= '0;
    else if (!settleDone) settleCount <= settleCount + `PSM_SETTLE_W'(1); // see [R14]
  end

  // the rtc and wakeup path is never gated; its oscillator is not ours to stop
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rtcClockOn <= 1'b1;
    else rtcClockOn <= 1'b1; // see [R09]
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) modemRingIrq <= 1'b0;
    else modemRingIrq <= wakeSync.modemRing && // see [R12]
        !(next_powerState inside {PS_SLEEP, PS_DEEP});
  end

  // a peripheral only sees a clock while it is active and clocks run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      periphClockOn <= '0;
      videoPowerOn <= 1'b0;
    end else begin
      periphClockOn <= periphActive & {`PSM_PERIPH_N{next_ctrl.internalClockOn}}; // see [R13]
      videoPowerOn <= monitorSync && next_ctrl.peripheralPowerOn; // see [R13]
    end
  end

  sequence deepWakeStart_s;
    state == ST_DEEP && wakeAny ##1 state == ST_WAKEOSC;
  endsequence

  sequence wakeFinish_s;
    state == ST_WAKESR && !selfRefreshAck ##1 state inside {ST_RUN, ST_SLOW};
  endsequence

  oneState_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R01]
    $onehot(powerState) && $onehot(state))
    else $error("power state not one-hot");

  runClocks_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R02]
    powerState == PS_RUN && state == ST_RUN |->
      ctrl.internalClockOn && ctrl.sdramRefresh && !ctrl.selfRefreshReq && !ctrl.cpuHalfRate)
    else $error("run state without clocks or refresh");

  slowHalf_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R03]
    (powerState == PS_SLOW) == (ctrl.cpuHalfRate && state inside {ST_SLOW, ST_IDLEREQ}))
    else $error("cpu half rate does not match slow state");

  idleBus_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R04]
    state == ST_IDLEREQ && busGrant && !leaveIdle |=> state == ST_IDLE && ctrl.busRequest)
    else $error("idle entered without holding the bus");

  idleExit_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R05]
    state == ST_IDLE && leaveIdle |=> !ctrl.busRequest && powerState inside {PS_RUN, PS_SLOW})
    else $error("idle not left on interrupt or dma request");

  sleepEntry_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R07]
    state == ST_SRENTER |-> $past(state) inside {ST_IDLE, ST_SRENTER} && ctrl.busRequest)
    else $error("sleep entry not from idle");

  sleepClocks_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R06]
    state == ST_SLEEP |-> ctrl.selfRefreshReq && !ctrl.internalClockOn && !ctrl.sdramRefresh)
    else $error("sleep without self-refresh or with clocks running");

  deepOff_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R08]
    powerState == PS_DEEP && state == ST_DEEP |->
      !ctrl.mainOscOn && !ctrl.pllOn && !ctrl.peripheralPowerOn && ctrl.selfRefreshReq && rtcClockOn)
    else $error("deep sleep with oscillator, pll or power on");

  sleepWake_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R11]
    state == ST_SLEEP && wakeAny |=> state == ST_WAKESR ##1 !ctrl.selfRefreshReq)
    else $error("sleep not left on wake event");

  ringIrq_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R12]
    modemRingIrq == ($past(wakeSync.modemRing) && !(powerState inside {PS_SLEEP, PS_DEEP})))
    else $error("ring interrupt does not follow ring outside sleep");

  deepWake_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R14]
    deepWakeStart_s |-> ctrl.mainOscOn && ctrl.pllOn && ctrl.selfRefreshReq && ctrl.busRequest)
    else $error("deep wake does not restart clocks under self-refresh");

  settleWait_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R14]
    state == ST_WAKESR && $past(state) == ST_WAKEOSC |->
      $past(settleCount) == SETTLE_LAST && $past(pllLocked))
    else $error("left oscillator settling too early");

  busRelease_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R14]
    wakeFinish_s |-> !ctrl.busRequest && !ctrl.selfRefreshReq)
    else $error("bus not released after self-refresh exit");

  gateClock_a: assert property (@(posedge clock) disable iff (!rst_b) // see [R13]
    !ctrl.internalClockOn |-> periphClockOn == '0)
    else $error("peripheral clock on while clocks gated");

endmodule : psm_power_state_manager

// file: psm_far_model.sv
// far side model: bus arbiter, sdram controller and pll lock for the power state manager
`timescale 1ns/10ps

module psm_far_model
  import psm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire psm_ctrl_t ctrl,
  input wire logic slowAns,
  output logic busGrant,
  output logic selfRefreshAck,
  output logic pllLockPin
);
  logic [3:0] grantCnt;
  logic [3:0] ackCnt;
  logic [5:0] lockCnt;

  // slow answers stall grant and ack so the waiting states are seen for several cycles
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      grantCnt <= 4'h0;
      busGrant <= 1'b0;
    end else if (!ctrl.busRequest) begin
      grantCnt <= 4'h0;
      busGrant <= 1'b0;
    end else if (grantCnt < (slowAns ? 4'h5 : 4'h1)) begin
      grantCnt <= grantCnt + 4'h1;
    end else begin
      busGrant <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ackCnt <= 4'h0;
      selfRefreshAck <= 1'b0;
    end else if (selfRefreshAck == ctrl.selfRefreshReq) begin
      ackCnt <= 4'h0;
    end else if (ackCnt < (slowAns ? 4'h6 : 4'h1)) begin
      ackCnt <= ackCnt + 4'h1;
    end else begin
      selfRefreshAck <= ctrl.selfRefreshReq;
    end
  end

  // lock drops at once when the pll stops, returns only after a lock time
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lockCnt <= 6'h00;
      pllLockPin <= 1'b1;
    end else if (!ctrl.pllOn) begin
      lockCnt <= 6'h00;
      pllLockPin <= 1'b0;
    end else if (lockCnt < 6'h14) begin
      lockCnt <= lockCnt + 6'h01;
    end else begin
      pllLockPin <= 1'b1;
    end
  end
endmodule : psm_far_model

// file: tb.sv
// self-checking testbench for the power state manager
`timescale 1ns/10ps

module tb
  import psm_pkg::*;
;
  logic clock, rst_b, targetValid, cpuIrq, dmaBusReq, monitorPin, slowAns;
  logic busGrant, selfRefreshAck, pllLockPin, rtcClockOn, modemRingIrq, videoPowerOn;
  psm_pstate_t targetState, powerState;
  psm_wake_t wakePins;
  psm_ctrl_t ctrl;
  logic [3:0] periphActive, periphClockOn;
  int failures, checks_done;

  psm_power_state_manager dut (.clock(clock), .rst_b(rst_b), .targetValid(targetValid),
    .targetState(targetState), .busGrant(busGrant), .cpuIrq(cpuIrq), .dmaBusReq(dmaBusReq),
    .selfRefreshAck(selfRefreshAck), .wakePins(wakePins), .pllLockPin(pllLockPin),
    .monitorPin(monitorPin), .periphActive(periphActive), .powerState(powerState),
    .ctrl(ctrl), .rtcClockOn(rtcClockOn), .modemRingIrq(modemRingIrq),
    .periphClockOn(periphClockOn), .videoPowerOn(videoPowerOn));

  psm_far_model far (.clock(clock), .rst_b(rst_b), .ctrl(ctrl), .slowAns(slowAns),
    .busGrant(busGrant), .selfRefreshAck(selfRefreshAck), .pllLockPin(pllLockPin));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic complete_run();
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic req(input psm_pstate_t st);
    @(posedge clock);
    targetValid <= 1'b1;
    targetState <= st;
    @(posedge clock);
    targetValid <= 1'b0;
    #1;
  endtask : req

  // bounded poll; a one-cycle state is still caught since it samples every cycle
  task automatic wait_ps(input psm_pstate_t exp);
    int n;
    n = 0;
    while (powerState !== exp && n < 1000) begin
      cyc(1);
      n++;
    end
    if (powerState !== exp) begin
      failures++;
      $display("BAD %0t timeout waiting for state %h", $time, exp);
      complete_run();
    end
  endtask : wait_ps

  task automatic run_slow();
    chk(8'(powerState), 8'(PS_RUN));
    chk(ctrl, 8'h2f);
    chk({7'h0, rtcClockOn}, 8'h01);
    req(PS_SLOW);
    chk(8'(powerState), 8'(PS_SLOW));
    chk({7'h0, ctrl.cpuHalfRate}, 8'h01);
    req(PS_SLEEP);
    req(PS_DEEP);
    cyc(2);
    chk(8'(powerState), 8'(PS_SLOW));
    chk({7'h0, ctrl.busRequest}, 8'h00);
    req(PS_RUN);
    chk(8'(powerState), 8'(PS_RUN));
  endtask : run_slow

  task automatic idle_leave(input int useDma);
    req(PS_IDLE);
    wait_ps(PS_IDLE);
    chk({7'h0, ctrl.busRequest}, 8'h01);
    cyc(3);
    chk(8'(powerState), 8'(PS_IDLE));
    @(posedge clock);
    cpuIrq <= (useDma == 0);
    dmaBusReq <= (useDma != 0);
    targetValid <= 1'b1;
    targetState <= PS_DEEP;
    @(posedge clock);
    targetValid <= 1'b0;
    #1;
    chk(8'(powerState), 8'(PS_RUN));
    chk({7'h0, ctrl.busRequest}, 8'h00);
    @(posedge clock);
    cpuIrq <= 1'b0;
    dmaBusReq <= 1'b0;
  endtask : idle_leave

  // from slow: an interrupt before the grant abandons the idle request, then idle back to run
  task automatic slow_idle_abort();
    req(PS_SLOW);
    @(posedge clock);
    slowAns <= 1'b1;
    req(PS_IDLE);
    chk(8'(powerState), 8'(PS_SLOW));
    chk({6'h0, ctrl.cpuHalfRate, ctrl.busRequest}, 8'h03);
    @(posedge clock);
    cpuIrq <= 1'b1;
    cyc(1);
    chk(8'(powerState), 8'(PS_SLOW));
    chk({6'h0, ctrl.cpuHalfRate, ctrl.busRequest}, 8'h02);
    @(posedge clock);
    cpuIrq <= 1'b0;
    req(PS_IDLE);
    wait_ps(PS_IDLE);
    chk({7'h0, ctrl.busRequest}, 8'h01);
    req(PS_RUN);
    chk(8'(powerState), 8'(PS_RUN));
    chk(ctrl, 8'h2f);
  endtask : slow_idle_abort

  // pass 0 stops in sleep, pass 2 asks for deep from sleep, passes 1 and 3 ask for deep from idle and reach it through sleep
  task automatic sleep_wake(input int src);
    @(posedge clock);
    slowAns <= src[0];
    periphActive <= 4'hf;
    req(PS_IDLE);
    wait_ps(PS_IDLE);
    req(src[0] ? PS_DEEP : PS_SLEEP);
    wait_ps(PS_SLEEP);
    chk({6'h0, ctrl.selfRefreshReq, ctrl.internalClockOn}, 8'h02);
    chk({4'h0, periphClockOn}, 8'h00);
    if (src == 2) req(PS_DEEP);
    if (src != 0) begin
      wait_ps(PS_DEEP);
      chk({4'h0, ctrl.mainOscOn, ctrl.pllOn, ctrl.peripheralPowerOn, ctrl.busRequest}, 8'h01);
      chk({6'h0, ctrl.selfRefreshReq, ctrl.sdramRefresh}, 8'h02);
      chk({7'h0, rtcClockOn}, 8'h01);
    end else begin
      cyc(4);
      chk(8'(powerState), 8'(PS_SLEEP));
      chk({7'h0, ctrl.mainOscOn}, 8'h01);
    end
    @(posedge clock);
    wakePins <= 4'(4'h8 >> src);
    cyc(3);
    chk({7'h0, modemRingIrq}, 8'h00);
    wait_ps(PS_RUN);
    chk(ctrl, 8'h2f);
    chk({7'h0, pllLockPin}, 8'h01);
    chk({4'h0, periphClockOn}, 8'h0f);
    @(posedge clock);
    wakePins <= 4'h0;
    cyc(4);
  endtask : sleep_wake

  task automatic ring_and_gating();
    @(posedge clock);
    wakePins <= 4'h1;
    periphActive <= 4'ha;
    monitorPin <= 1'b1;
    cyc(5);
    chk({7'h0, modemRingIrq}, 8'h01);
    chk({4'h0, periphClockOn}, 8'h0a);
    chk({7'h0, videoPowerOn}, 8'h01);
    chk(8'(powerState), 8'(PS_RUN));
    @(posedge clock);
    wakePins <= 4'h0;
    monitorPin <= 1'b0;
    periphActive <= 4'h5;
    cyc(5);
    chk({6'h0, modemRingIrq, videoPowerOn}, 8'h00);
    chk({4'h0, periphClockOn}, 8'h05);
  endtask : ring_and_gating

  // reset in mid idle with ring and monitor up, then a request straight after release
  task automatic reset_mid();
    @(posedge clock);
    wakePins <= 4'h1;
    monitorPin <= 1'b1;
    req(PS_IDLE);
    wait_ps(PS_IDLE);
    cyc(2);
    chk({6'h0, modemRingIrq, videoPowerOn}, 8'h03);
    @(posedge clock);
    rst_b <= 1'b0;
    #1;
    chk(8'(powerState), 8'(PS_RUN));
    chk(ctrl, 8'h2f);
    chk({2'h0, modemRingIrq, videoPowerOn, periphClockOn}, 8'h00);
    chk({7'h0, rtcClockOn}, 8'h01);
    cyc(2);
    @(posedge clock);
    wakePins <= 4'h0;
    monitorPin <= 1'b0;
    rst_b <= 1'b1;
    cyc(1);
    chk(8'(powerState), 8'(PS_RUN));
    chk({4'h0, periphClockOn}, 8'h05);
    req(PS_SLOW);
    chk(8'(powerState), 8'(PS_SLOW));
    req(PS_RUN);
  endtask : reset_mid

  initial begin
    failures = 0;
    checks_done = 0;
    rst_b = 1'b0;
    targetValid = 1'b0;
    targetState = PS_RUN;
    cpuIrq = 1'b0;
    dmaBusReq = 1'b0;
    wakePins = 4'h0;
    monitorPin = 1'b0;
    periphActive = 4'h0;
    slowAns = 1'b0;
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    cyc(1);
    run_slow();
    idle_leave(0);
    idle_leave(1);
    slow_idle_abort();
    for (int s = 0; s < 4; s++) begin
      sleep_wake(s);
    end
    ring_and_gating();
    reset_mid();
    complete_run();
  end
endmodule : tb
